// *** core/alusf_cfg.svh ***
// Constants for the ALU status flag datapath
`ifndef ALUSF_CFG_SVH
`define ALUSF_CFG_SVH

// Reset values of the architectural state
`define ALUSF_ACC_RESET 8'h00
`define ALUSF_AUX_RESET 8'h00
`define ALUSF_FLAG_RESET 1'h0

// Field positions of the flags in the flag write operand
`define ALUSF_FLD_CARRY 7
`define ALUSF_FLD_HALF 6
`define ALUSF_FLD_WRAP 2

// Decimal adjust constants
`define ALUSF_DIGIT_MAX 4'h9
`define ALUSF_BCD_LOW_ADJ 10'h006
`define ALUSF_BCD_HIGH_ADJ 10'h060
`define ALUSF_BCD_LIMIT 10'h099

// Product overflow limit
`define ALUSF_BYTE_MAX 16'h00FF

// Cycles from a taken divide to its done pulse
`define ALUSF_DIV_LATENCY 9

`endif

// *** core/alusf_pkg.sv ***
// Types shared by the ALU status flag datapath
`default_nettype none
package alusf_pkg;

  typedef enum logic [3:0] {
    op_nop,
    op_add,
    add_with_carry_op,
    subtract_with_borrow_op,
    product_op,
    quotient_op,
    decimal_adjust_op,
    rotate_right_through_carry,
    rotate_left_through_carry,
    compare_jump_unequal,
    op_load_acc,
    op_load_aux,
    op_write_flags
  } alusf_op_t;

  typedef enum logic {
    st_idle,
    st_divide
  } alusf_state_t;

  typedef struct packed {
    logic carry;
    logic wrap;
    logic half;
    logic [7:0] res;
  } alusf_arith_t;

endpackage
`default_nettype wire

// *** core/alusf_div_if.sv ***
// Request and answer signals between the core and its divider
`default_nettype none
interface alusf_div_if #(parameter int W = 8);
  logic start;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic done;
  logic [W-1:0] quotient;
  logic [W-1:0] remainder;
  logic zero_div;

  modport ctrl (output start, dividend, divisor, input done, quotient, remainder, zero_div);
  modport unit (input start, dividend, divisor, output done, quotient, remainder, zero_div);
endinterface
`default_nettype wire

// *** core/alusf_divider.sv ***
// Unsigned restoring divider, one quotient bit per clock
`default_nettype none
module alusf_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Divide request and answer
  alusf_div_if.unit div
);
  import alusf_pkg::*;

  localparam int CW = $clog2(W + 1);

  logic [W-1:0] rem_q, rem_d, quo_q, quo_d, dsr_q, dsr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d, done_q, done_d, zero_q, zero_d;
  logic [W:0] shifted;
  logic [W:0] diff;

  assign shifted = {rem_q, quo_q[W-1]};
  assign diff = shifted - {1'b0, dsr_q};

  always_comb begin
    rem_d = rem_q;
    quo_d = quo_q;
    dsr_d = dsr_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    zero_d = zero_q;
    if (div.start) begin
      rem_d = '0;
      quo_d = div.dividend;
      dsr_d = div.divisor;
      cnt_d = CW'(W);
      busy_d = 1'b1;
      zero_d = (div.divisor == '0); // RULE13
    end else if (busy_q) begin
      // Zero divisor runs the same steps; result is left undefined
      if (shifted >= {1'b0, dsr_q}) begin
        rem_d = diff[W-1:0];
        quo_d = {quo_q[W-2:0], 1'b1};
      end else begin
        rem_d = shifted[W-1:0];
        quo_d = {quo_q[W-2:0], 1'b0};
      end
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == CW'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rem_q <= '0;
      quo_q <= '0;
      dsr_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      zero_q <= 1'b0;
    end else begin
      rem_q <= rem_d;
      quo_q <= quo_d;
      dsr_q <= dsr_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      zero_q <= zero_d;
    end
  end

  assign div.done = done_q;
  assign div.quotient = quo_q;
  assign div.remainder = rem_q;
  assign div.zero_div = zero_q;
endmodule
`default_nettype wire

// *** core/alusf_core.sv ***
// ALU datapath with carry, signed wrap and half carry status flags
`include "alusf_cfg.svh"
`default_nettype none
// Summary of operation
// RULE1: Plain add sums source and accumulator into accumulator, ignoring carry.
// RULE2: Additions set carry on carry out of bit seven, else clear.
// RULE3: Additions set signed wrap to carry out of bit six xor bit seven.
// RULE4: Additions set half carry on carry out of bit three, else clear.
// RULE5: Add with carry also adds the carry flag; flags as plain add.
// RULE6: Subtract with borrow removes source and carry from accumulator.
// RULE7: Subtract sets carry when bit seven needs a borrow.
// RULE8: Subtract sets signed wrap when exactly one of bits six, seven borrows.
// RULE9: Subtract sets half carry when bit three needs a borrow.
// RULE10: Multiply accumulator by auxiliary; low byte to accumulator, high to auxiliary.
// RULE11: Multiply clears carry, sets signed wrap when product exceeds 255.
// RULE12: Divide accumulator by auxiliary; quotient to accumulator, remainder to auxiliary.
// RULE13: Divide clears carry; signed wrap set only for zero divisor.
// RULE14: Decimal adjust adds 0x06 when half carry or low digit above nine.
// RULE15: Decimal adjust adds 0x60 when carry was set or 0x06 was added.
// RULE16: Decimal adjust sets carry when adjusted result exceeds 0x99.
// RULE17: Rotate right through carry: old bit zero to carry, carry to bit seven.
// RULE18: Rotate left through carry: old bit seven to carry, carry to bit zero.
// RULE19: Compare branches when destination and source differ, else falls through.
// RULE20: Compare sets carry when source exceeds destination as unsigned bytes.
// RULE21: Flags an operation does not touch keep their values.
module alusf_core (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Operation request from the sequencer
  input wire logic op_valid,
  input wire alusf_pkg::alusf_op_t op,
  input wire logic [7:0] src_operand,
  input wire logic [7:0] dst_operand,
  output logic op_ready,
  // Completion
  output logic op_done,
  output logic branch_taken,
  // Architectural state
  output logic [7:0] accumulator,
  output logic [7:0] aux_operand,
  output logic carry_flag,
  output logic signed_wrap_flag,
  output logic half_carry_flag
);
  import alusf_pkg::*;

  // Sum with carries out of bits three, six and seven
  function automatic alusf_arith_t alusf_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
    alusf_arith_t r;
    logic [4:0] low;
    logic [7:0] mid;
    logic [8:0] full;
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    mid = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    r.res = full[7:0];
    r.carry = full[8]; // RULE2
    r.wrap = mid[7] ^ full[8]; // RULE3
    r.half = low[4]; // RULE4
    return r;
  endfunction

  // Difference with borrows into bits three, six and seven
  function automatic alusf_arith_t alusf_sub(input logic [7:0] a, input logic [7:0] b, input logic bin);
    alusf_arith_t r;
    logic [4:0] low;
    logic [7:0] mid;
    logic [8:0] full;
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    mid = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, bin};
    full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    r.res = full[7:0];
    r.carry = full[8]; // RULE7
    r.wrap = mid[7] ^ full[8]; // RULE8
    r.half = low[4]; // RULE9
    return r;
  endfunction

  alusf_state_t state_q, state_d;
  logic [7:0] acc_q, acc_d, aux_q, aux_d;
  logic carry_q, carry_d, wrap_q, wrap_d, half_q, half_d;
  logic done_q, done_d, branch_q, branch_d;
  logic op_take;
  alusf_arith_t add_r, cadd_r, sub_r;
  logic [15:0] product;
  logic dec_low, dec_high;
  logic [9:0] dec_sum;

  alusf_div_if #(.W(8)) div_bus ();

  alusf_divider #(.W(8)) u_divider (
    .clock(clock),
    .reset_n(reset_n),
    .div(div_bus)
  );

  // Divider is the only multi-cycle path, so only it holds off requests
  assign op_ready = (state_q == st_idle);
  assign op_take = op_valid && op_ready;

  assign add_r = alusf_add(acc_q, src_operand, 1'b0); // RULE1
  assign cadd_r = alusf_add(acc_q, src_operand, carry_q); // RULE5
  assign sub_r = alusf_sub(acc_q, src_operand, carry_q); // RULE6
  assign product = 16'(acc_q) * 16'(aux_q); // RULE10

  // Both corrections fold into one ten-bit sum
  assign dec_low = half_q || (acc_q[3:0] > `ALUSF_DIGIT_MAX); // RULE14
  assign dec_high = carry_q || dec_low; // RULE15
  assign dec_sum = {2'b00, acc_q} + (dec_low ? `ALUSF_BCD_LOW_ADJ : 10'h000)
    + (dec_high ? `ALUSF_BCD_HIGH_ADJ : 10'h000);

  assign div_bus.start = op_take && (op == quotient_op);
  assign div_bus.dividend = acc_q;
  assign div_bus.divisor = aux_q;

  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    aux_d = aux_q;
    carry_d = carry_q; // RULE21
    wrap_d = wrap_q; // RULE21
    half_d = half_q; // RULE21
    done_d = 1'b0;
    branch_d = branch_q;
    unique case (state_q)
      st_idle: begin
        if (op_valid) begin
          done_d = 1'b1;
          unique case (op)
            op_nop: begin
            end
            op_add: begin
              acc_d = add_r.res; // RULE1
              carry_d = add_r.carry; // RULE2
              wrap_d = add_r.wrap; // RULE3
              half_d = add_r.half; // RULE4
            end
            add_with_carry_op: begin
              acc_d = cadd_r.res; // RULE5
              carry_d = cadd_r.carry;
              wrap_d = cadd_r.wrap;
              half_d = cadd_r.half;
            end
            subtract_with_borrow_op: begin
              acc_d = sub_r.res; // RULE6
              carry_d = sub_r.carry; // RULE7
              wrap_d = sub_r.wrap; // RULE8
              half_d = sub_r.half; // RULE9
            end
            product_op: begin
              acc_d = product[7:0]; // RULE10
              aux_d = product[15:8];
              carry_d = 1'b0; // RULE11
              wrap_d = (product > `ALUSF_BYTE_MAX); // RULE11
            end
            quotient_op: begin
              done_d = 1'b0;
              state_d = st_divide; // RULE12
            end
            decimal_adjust_op: begin
              acc_d = dec_sum[7:0]; // RULE15
              carry_d = (dec_sum > `ALUSF_BCD_LIMIT); // RULE16
            end
            rotate_right_through_carry: begin
              acc_d = {carry_q, acc_q[7:1]}; // RULE17
              carry_d = acc_q[0];
            end
            rotate_left_through_carry: begin
              acc_d = {acc_q[6:0], carry_q}; // RULE18
              carry_d = acc_q[7];
            end
            compare_jump_unequal: begin
              branch_d = (dst_operand != src_operand); // RULE19
              carry_d = (src_operand > dst_operand); // RULE20
            end
            op_load_acc: begin
              acc_d = src_operand;
            end
            op_load_aux: begin
              aux_d = src_operand;
            end
            op_write_flags: begin
              carry_d = src_operand[`ALUSF_FLD_CARRY];
              half_d = src_operand[`ALUSF_FLD_HALF];
              wrap_d = src_operand[`ALUSF_FLD_WRAP];
            end
            default: begin
            end
          endcase
        end
      end
      st_divide: begin
        if (div_bus.done) begin
          acc_d = div_bus.quotient; // RULE12
          aux_d = div_bus.remainder;
          carry_d = 1'b0; // RULE13
          wrap_d = div_bus.zero_div; // RULE13
          done_d = 1'b1;
          state_d = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= st_idle;
      acc_q <= `ALUSF_ACC_RESET;
      aux_q <= `ALUSF_AUX_RESET;
      carry_q <= `ALUSF_FLAG_RESET;
      wrap_q <= `ALUSF_FLAG_RESET;
      half_q <= `ALUSF_FLAG_RESET;
      done_q <= 1'b0;
      branch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      aux_q <= aux_d;
      carry_q <= carry_d;
      wrap_q <= wrap_d;
      half_q <= half_d;
      done_q <= done_d;
      branch_q <= branch_d;
    end
  end

  assign op_done = done_q;
  assign branch_taken = branch_q;
  assign accumulator = acc_q;
  assign aux_operand = aux_q;
  assign carry_flag = carry_q;
  assign signed_wrap_flag = wrap_q;
  assign half_carry_flag = half_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  AST_ADD_SUM: assert property ( // RULE1
    op_take && op == op_add |=> accumulator == 8'($past(acc_q) + $past(src_operand)) && op_done)
    else $error("Plain add result wrong");
  AST_ADD_CARRY: assert property ( // RULE2
    op_take && op == op_add |=> carry_flag == (9'($past(acc_q)) + 9'($past(src_operand)) > 9'h0FF))
    else $error("Add carry wrong");
  AST_ADD_WRAP: assert property ( // RULE3
    op_take && op == op_add |=> signed_wrap_flag ==
      ($past(acc_q[7]) == $past(src_operand[7]) && accumulator[7] != $past(acc_q[7])))
    else $error("Add signed wrap wrong");
  AST_ADD_HALF: assert property ( // RULE4
    op_take && op == op_add |=> half_carry_flag ==
      (5'($past(acc_q[3:0])) + 5'($past(src_operand[3:0])) > 5'h0F))
    else $error("Add half carry wrong");
  AST_CADD_SUM: assert property ( // RULE5
    op_take && op == add_with_carry_op |=>
      accumulator == 8'($past(acc_q) + $past(src_operand) + 8'($past(carry_q))))
    else $error("Add with carry result wrong");
  AST_CADD_FLAGS: assert property ( // RULE5
    op_take && op == add_with_carry_op |=>
      carry_flag == (9'($past(acc_q)) + 9'($past(src_operand)) + 9'($past(carry_q)) > 9'h0FF)
      && half_carry_flag == (5'($past(acc_q[3:0])) + 5'($past(src_operand[3:0])) + 5'($past(carry_q)) > 5'h0F)
      && signed_wrap_flag == ($past(acc_q[7]) == $past(src_operand[7]) && accumulator[7] != $past(acc_q[7])))
    else $error("Add with carry flags wrong");
  AST_BSUB_DIFF: assert property ( // RULE6
    op_take && op == subtract_with_borrow_op |=>
      accumulator == 8'($past(acc_q) - $past(src_operand) - 8'($past(carry_q))))
    else $error("Subtract result wrong");
  AST_BSUB_CARRY: assert property ( // RULE7
    op_take && op == subtract_with_borrow_op |=>
      carry_flag == (9'($past(acc_q)) < 9'($past(src_operand)) + 9'($past(carry_q))))
    else $error("Subtract borrow wrong");
  AST_BSUB_WRAP: assert property ( // RULE8
    op_take && op == subtract_with_borrow_op |=> signed_wrap_flag ==
      ($past(acc_q[7]) != $past(src_operand[7]) && accumulator[7] != $past(acc_q[7])))
    else $error("Subtract signed wrap wrong");
  AST_BSUB_HALF: assert property ( // RULE9
    op_take && op == subtract_with_borrow_op |=>
      half_carry_flag == (5'($past(acc_q[3:0])) < 5'($past(src_operand[3:0])) + 5'($past(carry_q))))
    else $error("Subtract half borrow wrong");
  AST_MUL_BYTES: assert property ( // RULE10
    op_take && op == product_op |=> {aux_operand, accumulator} == 16'($past(acc_q)) * 16'($past(aux_q)))
    else $error("Product bytes wrong");
  AST_MUL_FLAGS: assert property ( // RULE11
    op_take && op == product_op |=> !carry_flag && signed_wrap_flag == (aux_operand != 8'h00))
    else $error("Product flags wrong");
  // Eight quotient steps, then the divider's done register, then the core's
  AST_DIV_DONE: assert property ( // RULE12
    op_take && op == quotient_op && aux_q != 8'h00 |=> !op_done [*8] ##1 !op_done ##1 op_done
      && accumulator == $past(acc_q, 10) / $past(aux_q, 10) && aux_operand == $past(acc_q, 10) % $past(aux_q, 10))
    else $error("Divide result or timing wrong");
  AST_DIV_BUSY: assert property ( // RULE12
    op_take && op == quotient_op |=> !op_ready [*8] ##1 !op_ready ##1 op_ready)
    else $error("Ready not held low while dividing");
  AST_DIV_FLAGS: assert property ( // RULE13
    op_take && op == quotient_op |-> ##10 !carry_flag && signed_wrap_flag == ($past(aux_q, 10) == 8'h00))
    else $error("Divide flags wrong");
  AST_DECADJ_CARRY: assert property ( // RULE16
    op_take && op == decimal_adjust_op && !carry_q && !half_q && acc_q[3:0] < 4'hA |=>
      accumulator == $past(acc_q) && carry_flag == ($past(acc_q) > 8'h99))
    else $error("Decimal adjust wrong");
  AST_DECADJ_LOW: assert property ( // RULE14
    op_take && op == decimal_adjust_op && (half_q || acc_q[3:0] > 4'h9) |=>
      accumulator == 8'($past(acc_q) + 8'h66) && carry_flag == (10'($past(acc_q)) + 10'h066 > 10'h099))
    else $error("Decimal adjust low step wrong");
  AST_DECADJ_HIGH: assert property ( // RULE15
    op_take && op == decimal_adjust_op && carry_q && !half_q && acc_q[3:0] < 4'hA |=>
      accumulator == 8'($past(acc_q) + 8'h60) && carry_flag == (10'($past(acc_q)) + 10'h060 > 10'h099))
    else $error("Decimal adjust high step wrong");
  AST_ROT_RIGHT: assert property ( // RULE17
    op_take && op == rotate_right_through_carry |=>
      carry_flag == $past(acc_q[0]) && accumulator[7] == $past(carry_q))
    else $error("Rotate right wrong");
  AST_ROT_LEFT: assert property ( // RULE18
    op_take && op == rotate_left_through_carry |=>
      carry_flag == $past(acc_q[7]) && accumulator[0] == $past(carry_q))
    else $error("Rotate left wrong");
  AST_CMP: assert property ( // RULE19
    op_take && op == compare_jump_unequal |=> branch_taken == ($past(dst_operand) != $past(src_operand))
      && carry_flag == ($past(src_operand) > $past(dst_operand)) && accumulator == $past(acc_q))
    else $error("Compare result wrong");
  AST_KEEP: assert property ( // RULE21
    op_take && (op == rotate_left_through_carry || op == compare_jump_unequal) |=>
      $stable(signed_wrap_flag) && $stable(half_carry_flag))
    else $error("Untouched flag changed");
  // Flags that these operations leave alone
  AST_HALF_KEEP: assert property ( // RULE21
    op_take && (op == product_op || op == decimal_adjust_op || op == rotate_right_through_carry) |=>
      $stable(half_carry_flag))
    else $error("Half carry changed by an operation that leaves it");
  AST_WRAP_KEEP: assert property ( // RULE21
    op_take && (op == decimal_adjust_op || op == rotate_right_through_carry) |=>
      $stable(signed_wrap_flag))
    else $error("Signed wrap changed by an operation that leaves it");
  AST_NOP_KEEP: assert property ( // RULE21
    op_take && op == op_nop |=> $stable(accumulator) && $stable(aux_operand) && $stable(carry_flag)
      && $stable(signed_wrap_flag) && $stable(half_carry_flag) && op_done)
    else $error("No-operation changed state");

  // Scenarios the bench is expected to reach
  COV_DIV_ZERO: cover property (op_take && op == quotient_op && aux_q == 8'h00 ##10 signed_wrap_flag);
  COV_ADD_WRAP: cover property (op_take && op == op_add ##1 signed_wrap_flag && carry_flag);
  COV_DECADJ_BOTH: cover property (op_take && op == decimal_adjust_op && dec_low && dec_high);
  COV_BRANCH: cover property (op_take && op == compare_jump_unequal ##1 branch_taken);
  COV_BSUB_WRAP: cover property (op_take && op == subtract_with_borrow_op ##1 signed_wrap_flag);
endmodule
`default_nettype wire

// *** verification/alusf_seq_model.sv ***
// Sequencer stand-in that issues one operation at a time to the datapath
`default_nettype none
module alusf_seq_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Operation request
  output logic op_valid,
  output var alusf_pkg::alusf_op_t op,
  output logic [7:0] src_operand,
  output logic [7:0] dst_operand,
  // Answer
  input wire logic op_ready,
  input wire logic op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  import alusf_pkg::*;

  initial begin
    op_valid = 1'b0;
    op = op_nop;
    src_operand = 8'h00;
    dst_operand = 8'h00;
  end

  // Holds the request until taken; lat counts edges to done, -1 on a hang
  task automatic issue(input alusf_op_t o, input logic [7:0] s, input logic [7:0] d, output int lat);
    int n;
    lat = -1;
    @(posedge clock);
    op_valid <= 1'b1;
    op <= o;
    src_operand <= s;
    dst_operand <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (op_ready === 1'b1 && reset_n === 1'b1) break;
    end
    // Released lines carry garbage so a stale value cannot pass
    op_valid <= 1'b0;
    op <= alusf_op_t'(~o);
    src_operand <= ~s;
    dst_operand <= ~d;
    if (n == 20) return;
    for (n = 1; n <= 20; n++) begin
      @(posedge clock);
      if (op_done === 1'b1) begin
        lat = n;
        return;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** verification/alu_status_flag_logic_test.sv ***
// Self-checking testbench for the ALU status flag datapath
`include "alusf_cfg.svh"
`default_nettype none
module alu_status_flag_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  import alusf_pkg::*;

  logic clock, reset_n, op_valid, op_ready, op_done, branch_taken;
  logic carry_flag, signed_wrap_flag, half_carry_flag;
  alusf_op_t op;
  logic [7:0] src_operand, dst_operand, accumulator, aux_operand;
  int n_fail, n_tests;

  alusf_core i_alusf_core (.clock(clock), .reset_n(reset_n), .op_valid(op_valid), .op(op),
    .src_operand(src_operand), .dst_operand(dst_operand), .op_ready(op_ready), .op_done(op_done),
    .branch_taken(branch_taken), .accumulator(accumulator), .aux_operand(aux_operand),
    .carry_flag(carry_flag), .signed_wrap_flag(signed_wrap_flag), .half_carry_flag(half_carry_flag));

  alusf_seq_model i_alusf_seq_model (.clock(clock), .reset_n(reset_n), .op_valid(op_valid), .op(op),
    .src_operand(src_operand), .dst_operand(dst_operand), .op_ready(op_ready), .op_done(op_done));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic results();
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Flags packed as carry, wrap, half in the low bits
  task automatic chk_fl(input logic c, input logic w, input logic h);
    chk8({5'h00, carry_flag, signed_wrap_flag, half_carry_flag}, {5'h00, c, w, h}, "flags");
  endtask

  task automatic chk_st(input logic [7:0] a, input logic c, input logic w, input logic h);
    chk8(accumulator, a, "accumulator");
    chk_fl(c, w, h);
  endtask

  task automatic run(input alusf_op_t o, input logic [7:0] s, input logic [7:0] d, input int exp_lat);
    int lat;
    i_alusf_seq_model.issue(o, s, d, lat);
    #1;
    if (lat < 0) begin
      n_fail++;
      $display("MISMATCH %0t operation never completed", $time);
      results();
    end
    chk8(8'(lat), 8'(exp_lat), "latency");
  endtask

  // Loads accumulator, auxiliary and flags; flag byte holds carry, half, wrap at 7, 6, 2
  task automatic set(input logic [7:0] a, input logic [7:0] b, input logic c, input logic h, input logic w);
    run(op_load_acc, a, 8'h00, 1);
    run(op_load_aux, b, 8'h00, 1);
    run(op_write_flags, {c, h, 3'h0, w, 2'h0}, 8'h00, 1);
  endtask

  task automatic t_reset();
    chk_st(8'h00, 1'b0, 1'b0, 1'b0);
    chk8({aux_operand[7:1], aux_operand[0] | branch_taken}, 8'h00, "aux and branch at reset");
    chk8({7'h00, op_ready}, 8'h01, "ready at reset");
  endtask

  task automatic t_arith();
    logic [7:0] av [6] = '{8'h00, 8'h7F, 8'h80, 8'hFF, 8'h0F, 8'h50};
    logic [7:0] sv [6] = '{8'h00, 8'h01, 8'h80, 8'h01, 8'h01, 8'hB1};
    alusf_op_t ops [3] = '{op_add, add_with_carry_op, subtract_with_borrow_op};
    int a, s, ce, o, ci;
    logic c, c6, h;
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 6; k++) begin
        a = av[i];
        s = sv[i];
        o = k / 2;
        ci = k % 2;
        ce = (o == 0) ? 0 : ci;
        if (o < 2) begin
          c = (a + s + ce) > 255;
          h = (a % 16 + s % 16 + ce) > 15;
          c6 = (a % 128 + s % 128 + ce) > 127;
        end else begin
          c = a < s + ce;
          h = a % 16 < s % 16 + ce;
          c6 = a % 128 < s % 128 + ce;
        end
        set(av[i], 8'h00, ci[0], ~ci[0], ci[0]);
        run(ops[o], sv[i], 8'h00, 1);
        chk_st((o < 2) ? 8'(a + s + ce) : 8'(a - s - ce), c, c6 ^ c, h);
      end
    end
  endtask

  task automatic t_mul();
    logic [7:0] av [3] = '{8'h10, 8'h0F, 8'hFF};
    logic [7:0] bv [3] = '{8'h10, 8'h11, 8'hFF};
    logic [15:0] p;
    for (int i = 0; i < 3; i++) begin
      p = av[i] * bv[i];
      set(av[i], bv[i], 1'b1, 1'b1, 1'b0);
      run(product_op, 8'h00, 8'h00, 1);
      chk8(aux_operand, p[15:8], "product high");
      chk_st(p[7:0], 1'b0, p > 16'h00FF, 1'b1);
    end
  endtask

  task automatic t_div();
    logic [7:0] av [3] = '{8'd200, 8'd7, 8'd255};
    logic [7:0] bv [3] = '{8'd7, 8'd200, 8'd1};
    // Count runs to the edge that shows done, one past the edge that raises it
    for (int i = 0; i < 3; i++) begin
      set(av[i], bv[i], 1'b1, 1'b1, 1'b1);
      run(quotient_op, 8'h00, 8'h00, `ALUSF_DIV_LATENCY + 1);
      chk8(aux_operand, av[i] % bv[i], "remainder");
      chk_st(av[i] / bv[i], 1'b0, 1'b0, 1'b1);
    end
    // Zero divisor: only the flags are defined
    set(8'h05, 8'h00, 1'b1, 1'b0, 1'b0);
    run(quotient_op, 8'h00, 8'h00, `ALUSF_DIV_LATENCY + 1);
    chk_fl(1'b0, 1'b1, 1'b0);
  endtask

  task automatic t_decadj();
    logic [7:0] av [6] = '{8'h9A, 8'h15, 8'h45, 8'h12, 8'h99, 8'hA0};
    logic cv [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic hv [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    int v;
    logic lo;
    for (int i = 0; i < 6; i++) begin
      v = av[i];
      lo = hv[i] || av[i][3:0] > 4'h9;
      if (lo) v += 6;
      if (cv[i] || lo) v += 'h60;
      set(av[i], 8'h00, cv[i], hv[i], 1'b1);
      run(decimal_adjust_op, 8'h00, 8'h00, 1);
      chk_st(8'(v), v > 'h99, 1'b1, hv[i]);
    end
  endtask

  task automatic t_rot();
    set(8'h81, 8'h00, 1'b0, 1'b1, 1'b1);
    run(rotate_right_through_carry, 8'h00, 8'h00, 1);
    chk_st(8'h40, 1'b1, 1'b1, 1'b1);
    run(rotate_left_through_carry, 8'h00, 8'h00, 1);
    chk_st(8'h81, 1'b0, 1'b1, 1'b1);
    run(rotate_left_through_carry, 8'h00, 8'h00, 1);
    chk_st(8'h02, 1'b1, 1'b1, 1'b1);
  endtask

  task automatic t_cmp();
    logic [7:0] sv [5] = '{8'h40, 8'h41, 8'h3F, 8'hFF, 8'h00};
    logic [7:0] dv [5] = '{8'h40, 8'h40, 8'h40, 8'h00, 8'h00};
    set(8'h33, 8'h00, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      run(compare_jump_unequal, sv[i], dv[i], 1);
      chk8({7'h00, branch_taken}, {7'h00, sv[i] != dv[i]}, "branch");
      chk_st(8'h33, sv[i] > dv[i], 1'b1, 1'b1);
    end
    run(op_nop, 8'hFF, 8'hFF, 1);
    chk8({7'h00, branch_taken}, 8'h00, "branch held");
    chk_st(8'h33, 1'b0, 1'b1, 1'b1);
  endtask

  initial begin
    n_fail = 0;
    n_tests = 0;
    reset_n = 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_arith();
    t_mul();
    t_div();
    t_decadj();
    t_rot();
    t_cmp();
    results();
  end
endmodule
`default_nettype wire
